// ---- test/cbcr_host_model.sv ----
// host side of the block read: start, then ack bytes until the last
`timescale 1ns/100ps
module cbcr_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] blk_data_r,
    input  wire logic       blk_last_r,
    output logic            blk_start,
    output logic [7:0]      blk_index,
    output logic            blk_next
);
    logic [7:0] got [0:40];
    int         n = 0;
    initial begin
        blk_start = 1'b0;
        blk_index = 8'h00;
        blk_next = 1'b0;
    end
    // gap 0 holds the ack up for back-to-back bytes
    task automatic block_read(input logic [7:0] idx, input int gap);
        logic last;
        n = 0;
        @(negedge mclk);
        blk_start = 1'b1;
        blk_index = idx;
        @(negedge mclk);
        blk_start = 1'b0;
        blk_index = ~idx;
        do begin
            got[n] = blk_data_r;
            last = blk_last_r;
            n++;
            blk_next = 1'b1;
            @(negedge mclk);
            if (last || gap > 0)
                blk_next = 1'b0;
            repeat (gap) @(negedge mclk);
        end while (!last && n < 40);
    endtask : block_read
endmodule : cbcr_host_model

// ---- test/cbcr_regs_props.sv ----
// port-level checks of the config bank
`include "cbcr_map.svh"
`timescale 1ns/100ps
module cbcr_regs_props
    import cbcr_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire cbcr_req_t  req,
    input wire logic [7:0] rd_data_r,
    input wire logic       blk_start,
    input wire logic       blk_next,
    input wire logic       blk_last_r,
    input wire logic       blk_busy_r,
    input wire logic       output_enable_n_pin,
    input wire logic [1:0] disabled_state_select,
    input wire cbcr_pair_t pair_six_r,
    input wire logic [1:0] swing_select_r,
    input wire logic [6:0] edge_rate_select_r
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    rsvd_ones_a: assert property (req.rd && req.addr == 8'h04 |=> rd_data_r == 8'hff)
        else $error("byte 4 not all ones");
    ident_rev_a: assert property (req.rd && req.addr == 8'h05 |=>
        rd_data_r == {`CBCR_REVISION_CODE, `CBCR_MAKER_CODE}) else $error("byte 5 wrong");
    ident_dev_a: assert property (req.rd && req.addr == 8'h06 |=>
        rd_data_r == {`CBCR_CATEGORY_CODE, `CBCR_DEVICE_CODE}) else $error("byte 6 wrong");
    swing_wr_a: assert property (req.wr && req.addr == 8'h01 |=>
        swing_select_r == $past(req.wdata[1:0])) else $error("swing not written");
    edge_wr_a: assert property (req.wr && req.addr == 8'h02 |=> edge_rate_select_r[5:0] ==
        {$past(req.wdata[7:6]), $past(req.wdata[4:2]), $past(req.wdata[0])})
        else $error("edge rates not written");
    edge_six_a: assert property (req.wr && req.addr == 8'h03 |=>
        edge_rate_select_r[6] == $past(req.wdata[0])) else $error("edge six not written");
    en_off_a: assert property (req.wr && req.addr == 8'h01 && !req.wdata[5] |-> ##2
        !pair_six_r.run) else $error("pair runs while disabled");
    pin_off_a: assert property (output_enable_n_pin [*4] |-> !pair_six_r.run)
        else $error("pair runs with pin inactive");
    dis_state_a: assert property (!pair_six_r.run && $past(rst_n) |->
        {pair_six_r.true_oe, pair_six_r.comp_oe} == {2{$past(disabled_state_select) != 2'h1}}
        && ($past(disabled_state_select) == 2'h1 || {pair_six_r.true_lvl, pair_six_r.comp_lvl}
        == {$past(disabled_state_select) == 2'h2, $past(disabled_state_select) == 2'h3}))
        else $error("disabled levels wrong");
    blk_end_a: assert property (blk_busy_r && blk_last_r && blk_next && !blk_start |=>
        !blk_busy_r && !blk_last_r) else $error("block read not ended");
    cover property (blk_busy_r && blk_last_r && blk_next);
    cover property (pair_six_r.run);
    cover property (!pair_six_r.run && !pair_six_r.true_oe);
endmodule : cbcr_regs_props

bind cbcr_regs cbcr_regs_props u_props (.mclk, .rst_n, .req, .rd_data_r, .blk_start,
    .blk_next, .blk_last_r, .blk_busy_r, .output_enable_n_pin, .disabled_state_select,
    .pair_six_r, .swing_select_r, .edge_rate_select_r);

// ---- test/cbcr_regs_tb.sv ----
// self-checking bench for the config bank
`include "cbcr_map.svh"
`timescale 1ns/100ps
module cbcr_regs_tb;
    import cbcr_pkg::*;
    logic       mclk = 0;
    logic       rst_n = 0;
    cbcr_req_t  req = '0;
    logic       pin_n = 0;
    logic [1:0] dss = 0;
    logic [7:0] rd_data_r, blk_data_r, blk_index;
    logic       rd_valid_r, blk_start, blk_next, blk_last_r, blk_busy_r;
    cbcr_pair_t pair_six_r;
    logic [1:0] swing_select_r;
    logic [6:0] edge_rate_select_r;
    int         err_total = 0;
    int         comparisons = 0;
    integer     seed = 32'hc7af;
    logic       s_en = 1'b1;
    logic [1:0] s_sw = 2'h2;
    logic [6:0] s_er = 7'h7f;
    logic [4:0] s_cnt = 5'h08;
    always #5 mclk = ~mclk;
    cbcr_regs dut (.mclk, .rst_n, .req, .rd_data_r, .rd_valid_r, .blk_start, .blk_index,
        .blk_next, .blk_data_r, .blk_last_r, .blk_busy_r, .output_enable_n_pin(pin_n),
        .disabled_state_select(dss), .pair_six_r, .swing_select_r, .edge_rate_select_r);
    cbcr_host_model host (.mclk, .blk_data_r, .blk_last_r, .blk_start, .blk_index, .blk_next);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic logic [7:0] exp_rd(input logic [7:0] x);
        case (x)
            8'h01: return {2'b00, s_en, 3'b011, s_sw};
            8'h02: return {s_er[5:4], 1'b0, s_er[3:1], 1'b0, s_er[0]};
            8'h03: return {7'h23, s_er[6]};
            8'h04: return 8'hff;
            8'h05: return {`CBCR_REVISION_CODE, `CBCR_MAKER_CODE};
            8'h06: return {`CBCR_CATEGORY_CODE, `CBCR_DEVICE_CODE};
            8'h07: return {3'h0, s_cnt};
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    // pair six as {run, true_lvl, comp_lvl, true_oe, comp_oe}
    function automatic logic [4:0] exp_pair(input logic en, input logic pin,
                                            input logic [1:0] st);
        if (en && !pin)
            return 5'h13;
        case (st)
            2'h0: return 5'h03;
            2'h1: return 5'h00;
            2'h2: return 5'h0b;
            default: return 5'h07;
        endcase
    endfunction : exp_pair
    task automatic wr(input logic [7:0] x, input logic [7:0] v);
        @(negedge mclk);
        req = '{wr: 1'b1, rd: 1'b0, addr: x, wdata: v};
        @(negedge mclk);
        req.wr = 1'b0;
        req.wdata = ~v;
        case (x)
            8'h01: begin
                s_en = v[5];
                s_sw = v[1:0];
            end
            8'h02: s_er[5:0] = {v[7:6], v[4:2], v[0]};
            8'h03: s_er[6] = v[0];
            8'h07: s_cnt = v[4:0];
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] x);
        @(negedge mclk);
        req.rd = 1'b1;
        req.addr = x;
        @(negedge mclk);
        req.rd = 1'b0;
        chk(8'(rd_valid_r), 8'h01, "rd_valid");
        chk(rd_data_r, exp_rd(x), "rd_data");
        chk(8'(swing_select_r), 8'(s_sw), "swing");
        chk(8'(edge_rate_select_r), 8'(s_er), "edge_rate");
    endtask : rd
    task automatic blk(input logic [4:0] cnt, input logic [7:0] x, input int g);
        wr(8'h07, {3'h0, cnt});
        host.block_read(x, g);
        chk({7'h00, blk_busy_r}, 8'h00, "blk_busy");
        chk(host.got[0], {3'h0, s_cnt}, "blk_count");
        for (int k = 0; k < cnt; k++)
            chk(host.got[k+1], exp_rd(8'(x + k)), "blk_byte");
        chk(8'(host.n), {3'h0, s_cnt} + 8'h01, "blk_len");
    endtask : blk
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 9; i++)
            rd(8'(i));
        blk(5'h00, 8'h05, 0);
        blk(5'h1f, 8'h01, 0);
        blk(5'h02, 8'h05, 2);
        for (int i = 0; i < 200; i++) begin
            pin_n = 1'($random(seed));
            dss = 2'($random(seed));
            wr(8'($unsigned($random(seed)) % 9), 8'($random(seed)));
            rd(req.addr);
            chk({3'h0, pair_six_r}, {3'h0, exp_pair(s_en, pin_n, dss)}, "pair_six");
            if (i % 25 == 0)
                blk(5'($unsigned($random(seed)) % 13), 8'($unsigned($random(seed)) % 9), i % 3);
        end
        // a reset in mid-run must bring every writable field back to its default
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        s_en = 1'b1;
        s_sw = 2'h2;
        s_er = 7'h7f;
        s_cnt = 5'h08;
        for (int i = 1; i < 8; i++)
            rd(8'(i));
        summarize();
    end
    // a stalled handshake ends the run as a failure
    initial begin
        #200000;
        err_total++;
        summarize();
    end
endmodule : cbcr_regs_tb

// ---- verilog/cbcr_map.svh ----
// register offsets, field positions, reset values and fixed codes of the config bank
`ifndef CBCR_MAP_SVH
`define CBCR_MAP_SVH

`define CBCR_OFS_OUTPUT_ENABLE_SWING   8'h01
`define CBCR_OFS_EDGE_RATE_SELECT_A    8'h02
`define CBCR_OFS_EDGE_RATE_SELECT_B    8'h03
`define CBCR_OFS_RESERVED_ALL_ONES     8'h04
`define CBCR_OFS_REVISION_MAKER_IDENT  8'h05
`define CBCR_OFS_CATEGORY_DEVICE_IDENT 8'h06
`define CBCR_OFS_READBACK_LENGTH       8'h07

`define CBCR_BIT_PAIR_SIX_ENABLE       5
`define CBCR_BIT_EDGE5                 7
`define CBCR_BIT_EDGE4                 6
`define CBCR_BIT_EDGE3                 4
`define CBCR_BIT_EDGE2                 3
`define CBCR_BIT_EDGE1                 2
`define CBCR_BIT_EDGE0                 0
`define CBCR_BIT_EDGE6                 0

`define CBCR_RST_PAIR_SIX_ENABLE       1'b1
`define CBCR_RST_SWING                 2'h2
`define CBCR_RST_EDGE_RATE             7'h7f
`define CBCR_RST_READBACK_COUNT        5'h08

// reserved bits read back as fixed patterns
`define CBCR_RSVD_BYTE1                8'h0c
`define CBCR_RSVD_BYTE3                8'h46
`define CBCR_RSVD_BYTE4                8'hff
`define CBCR_READ_UNMAPPED             8'h00

// identification codes: values are arbitrary
`define CBCR_REVISION_CODE             4'h3
`define CBCR_MAKER_CODE                4'h5
`define CBCR_CATEGORY_CODE             2'h2
`define CBCR_DEVICE_CODE               6'h2a

// disabled-state encodings (true/complement)
`define CBCR_DIS_LOW_LOW               2'h0
`define CBCR_DIS_HIZ_HIZ               2'h1
`define CBCR_DIS_HIGH_LOW              2'h2
`define CBCR_DIS_LOW_HIGH              2'h3

`endif

// ---- verilog/cbcr_pkg.sv ----
// types shared by the clock buffer config bank
package cbcr_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cbcr_req_t;

    typedef struct packed {
        logic       run;
        logic       true_lvl;
        logic       comp_lvl;
        logic       true_oe;
        logic       comp_oe;
    } cbcr_pair_t;

    typedef enum logic [1:0] {
        CBCR_BLK_IDLE = 2'b00,
        CBCR_BLK_SEND = 2'b01
    } cbcr_blk_state_t;

endpackage : cbcr_pkg

// ---- verilog/cbcr_regs.sv ----
// configuration and identification bytes 1..7 of the clock buffer, with block-read sequencer
//
// Operation
// - byte 1 bit 5 enables pair six
// - cleared enable overrides active-low enable pin
// - byte 1 bits 1:0 select output swing
// - byte 2 holds edge rates outputs zero-five
// - byte 3 bit 0 edge rate output six
// - byte 4 always reads all ones
// - byte 5 fixed revision and maker codes
// - byte 6 fixed category and device codes
// - byte 7 bits 4:0 block read count
// - disabled-state field sets disabled pair levels
// - block read returns count then consecutive bytes
`include "cbcr_map.svh"
`timescale 1ns/100ps
module cbcr_regs
    import cbcr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire cbcr_req_t  req,
    output logic [7:0]      rd_data_r,
    output logic            rd_valid_r,
    input  wire logic       blk_start,
    input  wire logic [7:0] blk_index,
    input  wire logic       blk_next,
    output logic [7:0]      blk_data_r,
    output logic            blk_last_r,
    output logic            blk_busy_r,
    input  wire logic       output_enable_n_pin,
    input  wire logic [1:0] disabled_state_select,
    output cbcr_pair_t      pair_six_r,
    output logic [1:0]      swing_select_r,
    output logic [6:0]      edge_rate_select_r
);
    logic            pair_six_enable_r;
    logic            pair_six_enable_nxt;
    logic [1:0]      swing_nxt;
    logic [6:0]      edge_rate_nxt;
    logic [4:0]      readback_count_r;
    logic [4:0]      readback_count_nxt;
    logic [7:0]      rd_data_nxt;
    logic            rd_valid_nxt;

    cbcr_blk_state_t blk_state_r;
    cbcr_blk_state_t blk_state_nxt;
    logic [7:0]      blk_ptr_r;
    logic [7:0]      blk_ptr_nxt;
    logic [4:0]      blk_left_r;
    logic [4:0]      blk_left_nxt;
    logic [7:0]      blk_data_nxt;
    logic            blk_last_nxt;

    cbcr_pair_t      pair_nxt;
    logic            oe_n_sync;

    // byte read mux, shared by single reads and the block sequencer
    function automatic logic [7:0] read_byte(
        input logic [7:0] addr,
        input logic       en6,
        input logic [1:0] swing,
        input logic [6:0] edge_rate,
        input logic [4:0] count
    );
        logic [7:0] v;
        v = `CBCR_READ_UNMAPPED;
        if (addr == `CBCR_OFS_OUTPUT_ENABLE_SWING) begin
            v = `CBCR_RSVD_BYTE1;
            v[`CBCR_BIT_PAIR_SIX_ENABLE] = en6;
            v[1:0] = swing;
        end else if (addr == `CBCR_OFS_EDGE_RATE_SELECT_A) begin
            v = 8'h00;
            v[`CBCR_BIT_EDGE5] = edge_rate[5];
            v[`CBCR_BIT_EDGE4] = edge_rate[4];
            v[`CBCR_BIT_EDGE3] = edge_rate[3];
            v[`CBCR_BIT_EDGE2] = edge_rate[2];
            v[`CBCR_BIT_EDGE1] = edge_rate[1];
            v[`CBCR_BIT_EDGE0] = edge_rate[0];
        end else if (addr == `CBCR_OFS_EDGE_RATE_SELECT_B) begin
            v = `CBCR_RSVD_BYTE3;
            v[`CBCR_BIT_EDGE6] = edge_rate[6];
        end else if (addr == `CBCR_OFS_RESERVED_ALL_ONES) begin
            v = `CBCR_RSVD_BYTE4;
        end else if (addr == `CBCR_OFS_REVISION_MAKER_IDENT) begin
            v = {`CBCR_REVISION_CODE, `CBCR_MAKER_CODE};
        end else if (addr == `CBCR_OFS_CATEGORY_DEVICE_IDENT) begin
            v = {`CBCR_CATEGORY_CODE, `CBCR_DEVICE_CODE};
        end else if (addr == `CBCR_OFS_READBACK_LENGTH) begin
            v = {3'h0, count};
        end
        return v;
    endfunction : read_byte

    cbcr_sync u_oe_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (output_enable_n_pin),
        .sync_out (oe_n_sync)
    );

    // register writes; only the writable fields are stored, the rest is dropped
    always_comb begin
        pair_six_enable_nxt = pair_six_enable_r;
        swing_nxt           = swing_select_r;
        edge_rate_nxt       = edge_rate_select_r;
        readback_count_nxt  = readback_count_r;
        if (req.wr) begin
            if (req.addr == `CBCR_OFS_OUTPUT_ENABLE_SWING) begin
                pair_six_enable_nxt = req.wdata[`CBCR_BIT_PAIR_SIX_ENABLE];
                swing_nxt           = req.wdata[1:0];
            end else if (req.addr == `CBCR_OFS_EDGE_RATE_SELECT_A) begin
                edge_rate_nxt[5] = req.wdata[`CBCR_BIT_EDGE5];
                edge_rate_nxt[4] = req.wdata[`CBCR_BIT_EDGE4];
                edge_rate_nxt[3] = req.wdata[`CBCR_BIT_EDGE3];
                edge_rate_nxt[2] = req.wdata[`CBCR_BIT_EDGE2];
                edge_rate_nxt[1] = req.wdata[`CBCR_BIT_EDGE1];
                edge_rate_nxt[0] = req.wdata[`CBCR_BIT_EDGE0];
            end else if (req.addr == `CBCR_OFS_EDGE_RATE_SELECT_B) begin
                edge_rate_nxt[6] = req.wdata[`CBCR_BIT_EDGE6];
            end else if (req.addr == `CBCR_OFS_READBACK_LENGTH) begin
                readback_count_nxt = req.wdata[4:0];
            end
            // bytes 4..6 and all reserved bits take no write
        end
    end

    // single-byte read port, answer one cycle after the strobe
    always_comb begin
        rd_valid_nxt = req.rd;
        rd_data_nxt  = rd_data_r;
        if (req.rd) begin
            rd_data_nxt = read_byte(req.addr, pair_six_enable_r, swing_select_r,
                                    edge_rate_select_r, readback_count_r);
        end
    end

    // block read: count byte first, then bytes from the start index upward
    always_comb begin
        blk_state_nxt = blk_state_r;
        blk_ptr_nxt   = blk_ptr_r;
        blk_left_nxt  = blk_left_r;
        blk_data_nxt  = blk_data_r;
        blk_last_nxt  = blk_last_r;
        case (blk_state_r)
            CBCR_BLK_IDLE: begin
                if (blk_start) begin
                    blk_state_nxt = CBCR_BLK_SEND;
                    blk_ptr_nxt   = blk_index;
                    blk_left_nxt  = readback_count_r;
                    blk_data_nxt  = {3'h0, readback_count_r};
                    blk_last_nxt  = (readback_count_r == 5'h00);
                end
            end
            CBCR_BLK_SEND: begin
                if (blk_start) begin
                    // a fresh start restarts the sequence
                    blk_ptr_nxt  = blk_index;
                    blk_left_nxt = readback_count_r;
                    blk_data_nxt = {3'h0, readback_count_r};
                    blk_last_nxt = (readback_count_r == 5'h00);
                end else if (blk_next) begin
                    if (blk_last_r) begin
                        blk_state_nxt = CBCR_BLK_IDLE;
                        blk_last_nxt  = 1'b0;
                    end else begin
                        blk_data_nxt = read_byte(blk_ptr_r, pair_six_enable_r,
                                                 swing_select_r, edge_rate_select_r,
                                                 readback_count_r);
                        blk_ptr_nxt  = blk_ptr_r + 8'h01;
                        blk_left_nxt = blk_left_r - 5'h01;
                        blk_last_nxt = (blk_left_r == 5'h01);
                    end
                end
            end
            default: begin
                blk_state_nxt = CBCR_BLK_IDLE;
            end
        endcase
    end

    // pair six drive: the register bit beats the pin, pin is only a further gate
    always_comb begin
        pair_nxt.run      = pair_six_enable_r & ~oe_n_sync;
        pair_nxt.true_lvl = 1'b0;
        pair_nxt.comp_lvl = 1'b0;
        pair_nxt.true_oe  = 1'b1;
        pair_nxt.comp_oe  = 1'b1;
        if (!pair_nxt.run) begin
            case (disabled_state_select)
                `CBCR_DIS_LOW_LOW: begin
                    pair_nxt.true_lvl = 1'b0;
                    pair_nxt.comp_lvl = 1'b0;
                end
                `CBCR_DIS_HIZ_HIZ: begin
                    pair_nxt.true_oe = 1'b0;
                    pair_nxt.comp_oe = 1'b0;
                end
                `CBCR_DIS_HIGH_LOW: begin
                    pair_nxt.true_lvl = 1'b1;
                end
                default: begin
                    pair_nxt.comp_lvl = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pair_six_enable_r  <= `CBCR_RST_PAIR_SIX_ENABLE;
            swing_select_r     <= `CBCR_RST_SWING;
            edge_rate_select_r <= `CBCR_RST_EDGE_RATE;
            readback_count_r   <= `CBCR_RST_READBACK_COUNT;
            rd_data_r          <= 8'h00;
            rd_valid_r         <= 1'b0;
            blk_state_r        <= CBCR_BLK_IDLE;
            blk_ptr_r          <= 8'h00;
            blk_left_r         <= 5'h00;
            blk_data_r         <= 8'h00;
            blk_last_r         <= 1'b0;
            blk_busy_r         <= 1'b0;
            pair_six_r         <= '0;
        end else begin
            pair_six_enable_r  <= pair_six_enable_nxt;
            swing_select_r     <= swing_nxt;
            edge_rate_select_r <= edge_rate_nxt;
            readback_count_r   <= readback_count_nxt;
            rd_data_r          <= rd_data_nxt;
            rd_valid_r         <= rd_valid_nxt;
            blk_state_r        <= blk_state_nxt;
            blk_ptr_r          <= blk_ptr_nxt;
            blk_left_r         <= blk_left_nxt;
            blk_data_r         <= blk_data_nxt;
            blk_last_r         <= blk_last_nxt;
            blk_busy_r         <= (blk_state_nxt == CBCR_BLK_SEND);
            pair_six_r         <= pair_nxt;
        end
    end
endmodule : cbcr_regs

// ---- verilog/cbcr_sync.sv ----
// two-flop synchroniser for an asynchronous pin level
`timescale 1ns/100ps
module cbcr_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // resets to one so an undriven active-low enable reads as inactive
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : cbcr_sync
